// ### design/operand_buffer_consts.svh
// Widths, encodings and counts for the operand staging datapath
`ifndef OPERAND_BUFFER_CONSTS_SVH
`define OPERAND_BUFFER_CONSTS_SVH
`define OB_WORD_W 32
`define OB_HALF_W 16
`define OB_OCT_WORDS 8
`define OB_OCT_W 256
`define OB_HALVES 16
`define OB_OPER_W 64
`define OB_ADDR_W 24
`define OB_BUF_DEPTH 2
`define OB_KIND_OPERAND 2'h0
`define OB_KIND_FILL 2'h1
`define OB_KIND_LOAD 2'h2
`define OB_SIZE_HALF 2'h0
`define OB_SIZE_SINGLE 2'h1
`define OB_SIZE_DOUBLE 2'h2
`define OB_SRC_A 2'h0
`define OB_SRC_B 2'h1
`define OB_SRC_LIT 2'h2
`endif

// ### design/operand_buffer_pkg.sv
// Types shared by the operand staging datapath
`include "operand_buffer_consts.svh"
package operand_buffer_pkg;
  typedef logic [`OB_OCT_W-1:0] octet_type;
  typedef logic [`OB_HALVES-1:0] half_flags_type;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_WRITE} store_state_type;
endpackage : operand_buffer_pkg

// ### design/octet_skid_buffer.sv
// Two-entry valid/ready buffer for arriving memory octets
`timescale 1ns/1ps
module octet_skid_buffer #(
  parameter int WIDTH = 258
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_q [2];
  logic rd_q, wr_q;
  logic [1:0] count_q, count_d;
  logic push, pop, ready_q;

  // Ready is a flop so the memory side never sees a count decode
  assign push = in_valid && ready_q;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_q;
  assign out_valid = (count_q != 2'h0);
  assign out_data = slot_q[rd_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) count_d = count_q + 2'h1;
    else if (pop && !push) count_d = count_q - 2'h1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      count_q <= 2'h0;
      ready_q <= 1'b1;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      count_q <= count_d;
      ready_q <= (count_d != 2'h2);
    end
  end

  // Data slots carry no reset; valid comes from count_q alone
  always_ff @(posedge mclk) begin
    if (push) slot_q[wr_q] <= in_data;
  end
endmodule : octet_skid_buffer

// ### design/operand_buffer_datapath.sv
// Operand staging datapath: intake, vector buffers, operand files, outputs, store octet
//
// Behaviour
// - Address words fetch the whole octet; immediates pass unchanged to the pipe.
// - Vector work buffers up to three octets per operand stream.
// - Intake file holds one eight-word octet until taken on the clock.
// - Intake goes straight to operand file unless vector buffers are in use.
// - Intake feeds result file only on load-details; fill path feeds store octet.
// - Each stream has entry and hold stages of one octet each.
// - Arriving octet is steered to the stream that requested it.
// - Entry moves to clear hold; hold moves to operand file once it empties.
// - Operand file loads whole octets from intake or hold stage, changed halfwords from result file.
// - Only changed halfwords are copied from result file into resident operand file.
// - A 4-bit word address picks half, single or double word.
// - Vector: A feeds first output, B second; scalar: both feed second.
// - Every operand reaches the pipe through the two 64-bit output registers.
// - Scalar: first output from register latch only; second from files or literal.
// - Vector: outputs fed from own file or a one-value literal.
// - Register latch waits for partner operand and advance enable, then loads first.
// - Literal feeds second output in scalar; loads vector parameters in vector.
// - Results are written to the result register named by the element address.
// - New store octet passes result file to store octet, full or not.
// - Holding file tracks result file one clock behind; store octet is taken from result file.
// - Lone modified halfword forces a memory read and merge before writing.
`timescale 1ns/1ps
module operand_buffer_datapath
  import operand_buffer_pkg::*;
#(
  parameter int ADDR_W = `OB_ADDR_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic vector_mode,
  input wire logic addr_valid,
  input wire logic [ADDR_W-1:0] addr_word,
  input wire logic addr_stream,
  output logic mem_req_valid_q,
  output logic [ADDR_W-4:0] mem_req_octet_q,
  output logic mem_req_stream_q,
  input wire logic mem_req_ack,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [`OB_OCT_W-1:0] mem_data,
  input wire logic mem_stream,
  input wire logic [1:0] mem_kind,
  input wire logic [1:0] opf_release,
  output logic [1:0] opf_full_q,
  input wire logic [3:0] sel_addr_a,
  input wire logic [1:0] sel_size_a,
  input wire logic [3:0] sel_addr_b,
  input wire logic [1:0] sel_size_b,
  input wire logic reg_load,
  input wire logic [`OB_OPER_W-1:0] reg_operand,
  input wire logic need_reg,
  input wire logic lit_load,
  input wire logic [`OB_OPER_W-1:0] lit_operand,
  input wire logic [1:0] second_src,
  input wire logic first_lit,
  input wire logic second_lit,
  input wire logic param_load,
  output logic [`OB_OPER_W-1:0] vector_params_q,
  input wire logic advance,
  input wire logic out_ready,
  output logic out_valid_q,
  output logic [`OB_OPER_W-1:0] first_output_operand,
  output logic [`OB_OPER_W-1:0] second_output_operand,
  input wire logic res_valid,
  input wire logic [`OB_WORD_W-1:0] res_data,
  input wire logic [3:0] res_elem,
  input wire logic res_half,
  input wire logic res_new_octet,
  input wire logic [1:0] res_hit,
  output logic res_accept_q,
  output logic fill_req_q,
  output logic store_valid_q,
  input wire logic store_ready,
  output logic [`OB_OCT_W-1:0] store_out_octet,
  output logic [`OB_OCT_WORDS-1:0] store_mask_q
);
  function automatic logic [`OB_OPER_W-1:0] pick(input octet_type oct, input logic [3:0] a,
                                                 input logic [1:0] sz);
    logic [`OB_OPER_W-1:0] r;
    r = oct[{a[3:2], 6'h00} +: `OB_OPER_W];
    if (sz == `OB_SIZE_HALF) r = {48'h0, oct[{a, 4'h0} +: `OB_HALF_W]};
    else if (sz == `OB_SIZE_SINGLE) r = {32'h0, oct[{a[3:1], 5'h00} +: `OB_WORD_W]};
    return r;
  endfunction : pick

  function automatic octet_type merge(input octet_type base, input octet_type src,
                                      input half_flags_type f);
    octet_type r;
    r = base;
    for (int i = 0; i < `OB_HALVES; i++) begin
      if (f[i]) r[i*`OB_HALF_W +: `OB_HALF_W] = src[i*`OB_HALF_W +: `OB_HALF_W];
    end
    return r;
  endfunction : merge

  // Arriving octets pass the two-entry buffer; a stalled stream backs up to memory
  logic buf_valid, buf_ready;
  logic [`OB_OCT_W+2:0] buf_data;
  octet_skid_buffer #(.WIDTH(`OB_OCT_W + 3)) u_arrival (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(mem_valid),
    .in_ready(mem_ready),
    .in_data({mem_kind, mem_stream, mem_data}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Intake file
  octet_type memory_intake_file;
  logic intake_v_q, intake_stream_q;
  logic [1:0] intake_kind_q;
  logic intake_drain;
  logic [1:0] take_direct, take_entry;
  logic [1:0] opf_v;
  octet_type opf [2];
  store_state_type state_q, state_d;

  wire is_operand = intake_v_q && (intake_kind_q == `OB_KIND_OPERAND);
  wire is_fill = intake_v_q && (intake_kind_q == `OB_KIND_FILL);
  wire is_load = intake_v_q && (intake_kind_q == `OB_KIND_LOAD);
  assign intake_drain = (|take_direct) || (|take_entry) || is_load ||
                        (is_fill && state_q == ST_FILL);
  assign buf_ready = !intake_v_q || intake_drain;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      intake_v_q <= 1'b0;
      intake_stream_q <= 1'b0;
      intake_kind_q <= `OB_KIND_OPERAND;
      memory_intake_file <= '0;
    end else if (buf_ready) begin
      intake_v_q <= buf_valid;
      if (buf_valid) begin
        memory_intake_file <= buf_data[`OB_OCT_W-1:0];
        intake_stream_q <= buf_data[`OB_OCT_W];
        intake_kind_q <= buf_data[`OB_OCT_W+2:`OB_OCT_W+1];
      end
    end
  end

  // Octet request toward memory; the requester keeps one pending at a time
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_req_valid_q <= 1'b0;
      mem_req_octet_q <= '0;
      mem_req_stream_q <= 1'b0;
    end else if (!mem_req_valid_q || mem_req_ack) begin
      mem_req_valid_q <= addr_valid;
      if (addr_valid) begin
        mem_req_octet_q <= addr_word[ADDR_W-1:3];
        mem_req_stream_q <= addr_stream;
      end
    end
  end

  // Result file, flags and holding file
  octet_type result_q, half_phase_hold_octet;
  half_flags_type flags_q, hold_flags_q;
  wire store_move = res_new_octet && (state_q == ST_IDLE);

  // Per-stream entry, hold and operand file stages
  for (genvar g = 0; g < 2; g++) begin : g_stream
    octet_type entry_q, hold_q, opf_q, opf_d;
    logic entry_v_q, hold_v_q, opf_v_q;
    wire mine = is_operand && (intake_stream_q == 1'(g));
    wire empty_path = !opf_v_q && !entry_v_q && !hold_v_q;
    wire hold_to_opf = hold_v_q && !opf_v_q;
    wire entry_to_hold = entry_v_q && !hold_v_q;
    wire upd = store_move && res_hit[g];
    assign take_direct[g] = mine && (vector_mode ? empty_path : !opf_v_q);
    assign take_entry[g] = mine && vector_mode && !empty_path && !entry_v_q;
    assign opf_v[g] = opf_v_q;
    assign opf[g] = opf_q;
    always_comb begin
      opf_d = opf_q;
      if (take_direct[g]) opf_d = memory_intake_file;
      else if (hold_to_opf) opf_d = hold_q;
      // Changed halfwords only, so unrelated words fetched from memory survive
      if (upd) opf_d = merge(opf_d, result_q, flags_q);
    end
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        entry_v_q <= 1'b0;
        hold_v_q <= 1'b0;
        opf_v_q <= 1'b0;
        entry_q <= '0;
        hold_q <= '0;
        opf_q <= '0;
      end else begin
        opf_q <= opf_d;
        if (take_entry[g]) entry_q <= memory_intake_file;
        if (entry_to_hold) hold_q <= entry_q;
        entry_v_q <= take_entry[g] || (entry_v_q && !entry_to_hold);
        hold_v_q <= entry_to_hold || (hold_v_q && !hold_to_opf);
        opf_v_q <= take_direct[g] || hold_to_opf || (opf_v_q && !opf_release[g]);
      end
    end
  end

  // Word selectors
  wire [`OB_OPER_W-1:0] sel_a = pick(opf[0], sel_addr_a, sel_size_a);
  wire [`OB_OPER_W-1:0] sel_b = pick(opf[1], sel_addr_b, sel_size_b);

  // Register-operand latch and literal register
  logic [`OB_OPER_W-1:0] reg_q, literal_operand_reg;
  logic reg_v_q, lit_v_q;
  wire out_free = !out_valid_q || out_ready;
  wire sec_lit = (second_src == `OB_SRC_LIT);
  wire sec_ok = sec_lit ? lit_v_q : opf_v[second_src[0]];
  wire fire_s = advance && sec_ok && (!need_reg || reg_v_q);
  wire a_ok = first_lit ? lit_v_q : opf_v[0];
  wire b_ok = second_lit ? lit_v_q : opf_v[1];
  wire fire_v = advance && a_ok && b_ok;
  wire fire = out_free && (vector_mode ? fire_v : fire_s);
  wire reg_used = fire && !vector_mode && need_reg;
  wire param_take = param_load && vector_mode && lit_v_q;
  wire lit_used = (fire && (vector_mode ? (first_lit || second_lit) : sec_lit)) ||
                  param_take;
  wire [`OB_OPER_W-1:0] sec_mem = second_src[0] ? sel_b : sel_a;
  wire [`OB_OPER_W-1:0] first_d = vector_mode ? (first_lit ? literal_operand_reg : sel_a)
                                              : reg_q;
  wire [`OB_OPER_W-1:0] second_d = vector_mode ? (second_lit ? literal_operand_reg : sel_b)
                                   : (sec_lit ? literal_operand_reg : sec_mem);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_v_q <= 1'b0;
      lit_v_q <= 1'b0;
      reg_q <= '0;
      literal_operand_reg <= '0;
      vector_params_q <= '0;
    end else begin
      // A new load in the consuming cycle wins over the clear
      reg_v_q <= reg_load || (reg_v_q && !reg_used);
      lit_v_q <= lit_load || (lit_v_q && !lit_used);
      if (reg_load) reg_q <= reg_operand;
      if (lit_load) literal_operand_reg <= lit_operand;
      if (param_take) vector_params_q <= literal_operand_reg;
    end
  end

  // Output registers: sole path to the pipe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      first_output_operand <= '0;
      second_output_operand <= '0;
    end else begin
      if (fire) out_valid_q <= 1'b1;
      else if (out_ready) out_valid_q <= 1'b0;
      if (fire && (vector_mode || need_reg)) first_output_operand <= first_d;
      if (fire) second_output_operand <= second_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) opf_full_q <= 2'h0;
    else opf_full_q <= opf_v;
  end

  // Result file writes; element address bit 0 picks the halfword
  logic [2:0] res_word;
  half_flags_type res_set;
  assign res_word = res_elem[3:1];
  always_comb begin
    res_set = '0;
    if (res_valid) begin
      if (res_half) res_set[res_elem] = 1'b1;
      else res_set[{res_word, 1'b0} +: 2] = 2'h3;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_q <= '0;
      flags_q <= '0;
      half_phase_hold_octet <= '0;
      hold_flags_q <= '0;
    end else begin
      if (is_load) begin
        result_q <= memory_intake_file;
      end else if (res_valid && res_half) begin
        result_q[{res_elem, 4'h0} +: `OB_HALF_W] <= res_data[`OB_HALF_W-1:0];
      end else if (res_valid) begin
        result_q[{res_word, 5'h00} +: `OB_WORD_W] <= res_data;
      end
      // A write in the hand-over cycle starts the next octet's flags
      if (is_load) flags_q <= '0;
      else if (store_move) flags_q <= res_set;
      else flags_q <= flags_q | res_set;
      half_phase_hold_octet <= result_q;
      hold_flags_q <= flags_q;
    end
  end

  // Store octet sequencing
  half_flags_type sflags_q;
  logic lone_half;
  always_comb begin
    lone_half = 1'b0;
    for (int w = 0; w < `OB_OCT_WORDS; w++) begin
      if (flags_q[2*w] ^ flags_q[2*w+1]) lone_half = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (store_move && |flags_q) state_d = lone_half ? ST_FILL : ST_WRITE;
      end
      ST_FILL: begin
        if (is_fill) state_d = ST_WRITE;
      end
      ST_WRITE: begin
        if (store_ready) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Store octet is captured with the same edge that would refresh the holding file
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      res_accept_q <= 1'b1;
      fill_req_q <= 1'b0;
      store_valid_q <= 1'b0;
      store_out_octet <= '0;
      store_mask_q <= '0;
      sflags_q <= '0;
    end else begin
      state_q <= state_d;
      res_accept_q <= (state_d == ST_IDLE);
      fill_req_q <= (state_d == ST_FILL);
      store_valid_q <= (state_d == ST_WRITE);
      if (store_move) begin
        store_out_octet <= result_q;
        sflags_q <= flags_q;
        for (int w = 0; w < `OB_OCT_WORDS; w++) begin
          store_mask_q[w] <= flags_q[2*w] | flags_q[2*w+1];
        end
      end else if (state_q == ST_FILL && is_fill) begin
        store_out_octet <= merge(memory_intake_file, store_out_octet, sflags_q);
      end
    end
  end
endmodule : operand_buffer_datapath

// ### verification/memory_side_model.sv
// Behavioural central memory answering octet requests and store fills
`timescale 1ns/1ps
module memory_side_model #(
  parameter logic [20:0] FILL_OCT = 21'h0abcd
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mem_req_valid_q,
  input wire logic [20:0] mem_req_octet_q,
  input wire logic mem_req_stream_q,
  output logic mem_req_ack,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [255:0] mem_data,
  output logic mem_stream,
  output logic [1:0] mem_kind,
  input wire logic fill_req_q
);
  typedef struct packed {logic [1:0] kind; logic stream; logic [20:0] oct;} beat_type;
  beat_type pend[$];
  logic fill_sent;
  logic [1:0] tick;
  wire logic go = !slow || tick == 2'h0;
  function automatic logic [255:0] octet_of(input beat_type b);
    for (int i = 0; i < 8; i++) octet_of[32*i +: 32] = {b.kind, 5'(i), b.stream, 3'h0, b.oct};
  endfunction : octet_of
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_req_ack <= 1'b0;
      mem_valid <= 1'b0;
      mem_data <= '1;
      mem_stream <= 1'b1;
      mem_kind <= 2'h3;
      fill_sent <= 1'b0;
      tick <= 2'h0;
      pend.delete();
    end else begin
      tick <= tick + 2'h1;
      mem_req_ack <= mem_req_valid_q && !mem_req_ack && go;
      if (mem_req_valid_q && mem_req_ack) begin
        pend.push_back({2'h0, mem_req_stream_q, mem_req_octet_q});
      end
      if (fill_req_q && !fill_sent) begin
        pend.push_back({2'h1, 1'b0, FILL_OCT});
      end
      fill_sent <= fill_req_q;
      // Released data and stream lines show the inverse so stale data never looks valid
      if (!mem_valid || mem_ready) begin
        if (pend.size() > 0 && go) begin
          mem_valid <= 1'b1;
          mem_data <= octet_of(pend[0]);
          mem_stream <= pend[0].stream;
          mem_kind <= pend[0].kind;
          void'(pend.pop_front());
        end else if (mem_valid) begin
          mem_valid <= 1'b0;
          mem_data <= ~mem_data;
          mem_stream <= ~mem_stream;
        end
      end
    end
  end
endmodule : memory_side_model

// ### verification/operand_buffer_checker.sv
// Port-level assertions for the operand staging datapath
`timescale 1ns/1ps
`include "operand_buffer_consts.svh"
module operand_buffer_checker #(
  parameter int ADDR_W = `OB_ADDR_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic vector_mode,
  input wire logic addr_valid,
  input wire logic [ADDR_W-1:0] addr_word,
  input wire logic addr_stream,
  input wire logic mem_req_valid_q,
  input wire logic [ADDR_W-4:0] mem_req_octet_q,
  input wire logic mem_req_stream_q,
  input wire logic mem_req_ack,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic [1:0] mem_kind,
  input wire logic need_reg,
  input wire logic out_ready,
  input wire logic out_valid_q,
  input wire logic [`OB_OPER_W-1:0] first_output_operand,
  input wire logic [`OB_OPER_W-1:0] second_output_operand,
  input wire logic fill_req_q,
  input wire logic store_valid_q,
  input wire logic store_ready,
  input wire logic [`OB_OCT_W-1:0] store_out_octet,
  input wire logic [`OB_OCT_WORDS-1:0] store_mask_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic [ADDR_W-4:0] addr_octet = addr_word[ADDR_W-1:3];
  property p_req_take;
    addr_valid && (!mem_req_valid_q || mem_req_ack) |=> mem_req_valid_q &&
      mem_req_octet_q == $past(addr_octet) && mem_req_stream_q == $past(addr_stream);
  endproperty
  a_req_take: assert property (p_req_take) else $error("octet request not raised");
  property p_req_hold;
    mem_req_valid_q && !mem_req_ack |=> mem_req_valid_q && $stable(mem_req_octet_q);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_out_hold;
    out_valid_q && !out_ready |=> out_valid_q && $stable(second_output_operand);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("operand lost in stall");
  property p_first_keep;
    !vector_mode && !need_reg |=> $stable(first_output_operand);
  endproperty
  a_first_keep: assert property (p_first_keep) else $error("first output loaded");
  property p_store_hold;
    store_valid_q && !store_ready |=> store_valid_q && $stable(store_out_octet) &&
      $stable(store_mask_q);
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store octet changed");
  property p_store_mask;
    store_valid_q |-> store_mask_q != 8'h00;
  endproperty
  a_store_mask: assert property (p_store_mask) else $error("empty store mask");
  property p_fill_block;
    fill_req_q |-> !store_valid_q;
  endproperty
  a_fill_block: assert property (p_fill_block) else $error("store before fill");
  property p_fill_done;
    fill_req_q && mem_valid && mem_ready && mem_kind == `OB_KIND_FILL |-> ##[1:4] store_valid_q;
  endproperty
  a_fill_done: assert property (p_fill_done) else $error("no store after fill");
  c_fill: cover property (fill_req_q ##1 !fill_req_q);
  c_store: cover property (store_valid_q && store_ready);
  c_out: cover property (out_valid_q && out_ready);
endmodule : operand_buffer_checker
bind operand_buffer_datapath operand_buffer_checker #(.ADDR_W(ADDR_W)) operand_buffer_checker_inst (.*);

// ### verification/testbench.sv
// Self-checking bench for the operand staging datapath
`timescale 1ns/1ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
`define WAIT_FOR(c) begin for (w = 0; w < 500 && !(c); w++) @(negedge mclk); \
  if (w == 500) begin fail_count++; results(); end end
module testbench;
  localparam logic [20:0] FILL_OCT = 21'h0abcd;
  int fail_count = 0, check_count = 0, w;
  logic mclk = 1'b0, resetn = 1'b0, slow = 1'b0, vector_mode = 1'b0, addr_valid = 1'b0;
  logic addr_stream = 1'b0, reg_load = 1'b0, need_reg = 1'b0, lit_load = 1'b0, first_lit = 1'b0;
  logic second_lit = 1'b0, param_load = 1'b0, advance = 1'b0, out_ready = 1'b0, res_valid = 1'b0;
  logic res_half = 1'b0, res_new_octet = 1'b0, store_ready = 1'b1;
  logic [23:0] addr_word = 24'h0;
  logic [1:0] opf_release = 2'h0, sel_size_a = 2'h1, sel_size_b = 2'h1, second_src = 2'h0;
  logic [1:0] res_hit = 2'h0, mem_kind, opf_full_q;
  logic [3:0] sel_addr_a = 4'h4, sel_addr_b = 4'h4, res_elem = 4'h0;
  logic [63:0] reg_operand = 64'h0, lit_operand = 64'h0;
  logic [31:0] res_data = 32'h0;
  logic mem_req_valid_q, mem_req_stream_q, mem_req_ack, mem_valid, mem_ready, mem_stream;
  logic out_valid_q, res_accept_q, fill_req_q, store_valid_q;
  logic [20:0] mem_req_octet_q;
  logic [255:0] mem_data, store_out_octet;
  logic [63:0] vector_params_q, first_output_operand, second_output_operand;
  logic [7:0] store_mask_q;
  operand_buffer_datapath operand_buffer_datapath_inst (.*);
  memory_side_model #(.FILL_OCT(FILL_OCT)) memory_side_model_inst (.*);
  always #5 mclk = ~mclk;
  function automatic logic [31:0] exp_word(input logic [1:0] k, input logic s,
                                           input logic [20:0] o, input int i);
    return {k, 5'(i), s, 3'h0, o};
  endfunction : exp_word
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic send_addr(input logic [23:0] a, input logic s);
    @(posedge mclk);
    addr_valid <= 1'b1;
    addr_word <= a;
    addr_stream <= s;
    @(negedge mclk);
    `WAIT_FOR(!mem_req_valid_q || mem_req_ack)
    @(posedge mclk);
    addr_valid <= 1'b0;
  endtask : send_addr
  task automatic take(input logic [3:0] sel);
    @(posedge mclk);
    sel_addr_a <= sel;
    sel_addr_b <= sel;
    advance <= 1'b1;
    @(posedge mclk);
    advance <= 1'b0;
  endtask : take
  task automatic release_file(input logic [1:0] g);
    @(posedge mclk);
    out_ready <= 1'b1;
    opf_release <= g;
    @(posedge mclk);
    opf_release <= 2'h0;
    out_ready <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : release_file
  task automatic t_scalar_fetch;
    logic [31:0] e;
    sel_size_a <= 2'h0;
    for (int g = 0; g < 2; g++) begin
      slow <= g[0];
      second_src <= 2'(g);
      out_ready <= 1'b0;
      send_addr(24'h012340 + 24'(g * 8), g[0]);
      `WAIT_FOR(opf_full_q[g])
      take(4'h4);
      // Hold the pipe off so the output must stand
      repeat (3) @(posedge mclk);
      `WAIT_FOR(out_valid_q)
      e = exp_word(2'h0, g[0], 21'h2468 + 21'(g), 2);
      `CHECK(second_output_operand, g ? {32'h0, e} : {48'h0, e[15:0]})
      release_file(2'(1 << g));
    end
    slow <= 1'b0;
  endtask : t_scalar_fetch
  task automatic t_reg_pair;
    @(posedge mclk);
    lit_load <= 1'b1;
    lit_operand <= 64'h5555_6666_7777_8888;
    @(posedge mclk);
    lit_load <= 1'b0;
    need_reg <= 1'b1;
    second_src <= 2'h2;
    take(4'h0);
    repeat (2) @(negedge mclk);
    `CHECK(out_valid_q, 1'b0)
    @(posedge mclk);
    reg_load <= 1'b1;
    reg_operand <= 64'h1111_2222_3333_4444;
    @(posedge mclk);
    reg_load <= 1'b0;
    take(4'h0);
    need_reg <= 1'b0;
    `WAIT_FOR(out_valid_q)
    `CHECK(first_output_operand, 64'h1111_2222_3333_4444)
    `CHECK(second_output_operand, 64'h5555_6666_7777_8888)
    release_file(2'h0);
  endtask : t_reg_pair
  task automatic t_vector;
    logic [31:0] e;
    vector_mode <= 1'b1;
    first_lit <= 1'b1;
    for (int k = 0; k < 6; k++) send_addr(24'h100000 + 24'(k * 8), 1'b1);
    `WAIT_FOR(!mem_ready)
    for (int k = 0; k < 6; k++) begin
      `WAIT_FOR(opf_full_q[1])
      @(posedge mclk);
      lit_load <= 1'b1;
      lit_operand <= 64'h0bad_cafe_0000_0001;
      @(posedge mclk);
      lit_load <= 1'b0;
      take(4'h4);
      `WAIT_FOR(out_valid_q)
      e = exp_word(2'h0, 1'b1, 21'h20000 + 21'(k), 2);
      `CHECK(second_output_operand, {32'h0, e})
      `CHECK(first_output_operand, 64'h0bad_cafe_0000_0001)
      release_file(2'h2);
    end
    vector_mode <= 1'b0;
    first_lit <= 1'b0;
  endtask : t_vector
  task automatic t_modes;
    logic [63:0] d;
    d = {exp_word(2'h0, 1'b0, 21'h40002, 3), exp_word(2'h0, 1'b0, 21'h40002, 2)};
    @(posedge mclk);
    vector_mode <= 1'b1;
    second_lit <= 1'b1;
    sel_size_a <= 2'h2;
    lit_load <= 1'b1;
    lit_operand <= 64'h1234_5678_9abc_def0;
    @(posedge mclk);
    lit_load <= 1'b0;
    param_load <= 1'b1;
    @(posedge mclk);
    param_load <= 1'b0;
    send_addr(24'h200010, 1'b0);
    `WAIT_FOR(opf_full_q[0])
    `CHECK(vector_params_q, 64'h1234_5678_9abc_def0)
    @(posedge mclk);
    lit_load <= 1'b1;
    @(posedge mclk);
    lit_load <= 1'b0;
    take(4'h4);
    `WAIT_FOR(out_valid_q)
    `CHECK(first_output_operand, d)
    `CHECK(second_output_operand, 64'h1234_5678_9abc_def0)
    release_file(2'h1);
    vector_mode <= 1'b0;
    second_lit <= 1'b0;
  endtask : t_modes
  task automatic t_store(input logic half, input logic [3:0] elem, input logic [31:0] d);
    `WAIT_FOR(res_accept_q)
    @(posedge mclk);
    res_valid <= 1'b1;
    res_data <= d;
    res_elem <= elem;
    res_half <= half;
    store_ready <= 1'b0;
    @(posedge mclk);
    res_valid <= 1'b0;
    res_new_octet <= 1'b1;
    @(posedge mclk);
    res_new_octet <= 1'b0;
    `WAIT_FOR(store_valid_q)
  endtask : t_store
  task automatic t_store_whole;
    t_store(1'b0, 4'h4, 32'hdead_beef);
    `CHECK(store_mask_q, 8'h04)
    `CHECK(store_out_octet[95:64], 32'hdead_beef)
    repeat (3) @(posedge mclk);
    store_ready <= 1'b1;
  endtask : t_store_whole
  task automatic t_store_fill;
    logic [31:0] f;
    logic [31:0] s;
    f = exp_word(2'h1, 1'b0, FILL_OCT, 1);
    t_store(1'b1, 4'h3, 32'h0000_a5a5);
    s = store_out_octet[63:32];
    `CHECK(store_mask_q, 8'h02)
    `CHECK(s == {16'ha5a5, f[15:0]} || s == {f[31:16], 16'ha5a5}, 1'b1)
    @(posedge mclk);
    store_ready <= 1'b1;
  endtask : t_store_fill
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_scalar_fetch();
    t_reg_pair();
    t_vector();
    t_modes();
    t_store_whole();
    t_store_fill();
    repeat (5) @(posedge mclk);
    results();
  end
endmodule : testbench
